// [logic/pdio_defs.vh]
// constants of the buffered parallel i/o card: register indices, field
// positions, reset values; included by the group and card design files
`ifndef PDIO_DEFS_VH
`define PDIO_DEFS_VH

// apb geometry: 32 word locations, byte address = 4 * index
`define PDIO_ADDR_W        7
`define PDIO_IDX_W         5
`define PDIO_IDX_LSB       2
`define PDIO_MAX_GROUPS    5
`define PDIO_GROUP_BITS    24
`define PDIO_FIELD_W       120

// per-group locations: index = 4 * group + port
`define PDIO_PORT_A        2'h0
`define PDIO_PORT_B        2'h1
`define PDIO_PORT_C        2'h2
`define PDIO_PORT_CTRL     2'h3

// card-wide locations
`define PDIO_IDX_STATUS    5'h14
`define PDIO_IDX_MASK      5'h15
`define PDIO_IDX_STATE     5'h16
`define PDIO_IDX_INT_OFF   5'h1e
`define PDIO_IDX_INT_ON    5'h1f

// port control fields: direction 1 = input, plus software buffer enable
`define PDIO_CTRL_W        5
`define PDIO_CTRL_DIR_A    0
`define PDIO_CTRL_DIR_B    1
`define PDIO_CTRL_DIR_CLO  2
`define PDIO_CTRL_DIR_CHI  3
`define PDIO_CTRL_BUF_EN   4
`define PDIO_CTRL_RST      5'h0f

// interrupt source and gate positions within a group's 24 lines
`define PDIO_BIT_INT_LINE  19
`define PDIO_BIT_GATE_LINE 23

// reset values of the card-wide mask and the group port latches
`define PDIO_MASK_RST      5'h1f
`define PDIO_PORT_RST      8'h00

`endif

// [logic/pdio_sync.v]
// two-flop synchroniser for a bundle of asynchronous levels
// assumes: levels are quasi-static or slow against pclk
`timescale 1ns/1ps
module pdio_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // levels
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  // first stage feeds only the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // pdio_sync

// [logic/pdio_group.v]
// one 24-bit group: two 8-bit ports, port c as two 4-bit halves,
// direction control, buffer control and the group's interrupt source
// assumes: pin and jumper inputs already synchronised to pclk
`timescale 1ns/1ps
`include "pdio_defs.vh"
module pdio_group (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // register access
  input  wire        wr_en,
  input  wire [1:0]  reg_sel,
  input  wire [7:0]  wdata,
  output reg  [7:0]  rdata,
  // jumpers and pins
  input  wire        buffer_force,
  input  wire        always_jumper,
  input  wire        gated_jumper,
  input  wire [23:0] pin_in,
  output wire [23:0] io_out,
  output wire [23:0] io_oe,
  output wire        buffer_enable,
  // interrupt event
  output wire        int_edge
);

  reg  [7:0]             port_a;
  reg  [7:0]             port_b;
  reg  [7:0]             port_c;
  reg  [`PDIO_CTRL_W-1:0] ctrl;
  reg                    int_line_q;
  wire [23:0]            dir_out;
  wire [23:0]            level;
  wire                   int_line;
  wire                   gate_line;
  wire                   grp_int_en;

  // port latches and control, inputs by default after reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a <= `PDIO_PORT_RST;
      port_b <= `PDIO_PORT_RST;
      port_c <= `PDIO_PORT_RST;
      ctrl   <= `PDIO_CTRL_RST;
    end else if (wr_en) begin
      case (reg_sel)
        `PDIO_PORT_A: port_a <= wdata;
        `PDIO_PORT_B: port_b <= wdata;
        `PDIO_PORT_C: port_c <= wdata;
        default:      ctrl   <= wdata[`PDIO_CTRL_W-1:0];
      endcase
    end
  end

  // per-port direction expanded to lines
  assign dir_out = {{4{~ctrl[`PDIO_CTRL_DIR_CHI]}}, {4{~ctrl[`PDIO_CTRL_DIR_CLO]}},
                    {8{~ctrl[`PDIO_CTRL_DIR_B]}}, {8{~ctrl[`PDIO_CTRL_DIR_A]}}};

  // buffers forced on by jumper, else software enable
  assign buffer_enable = buffer_force | ctrl[`PDIO_CTRL_BUF_EN];
  assign io_out        = {port_c, port_b, port_a};
  assign io_oe         = dir_out & {24{buffer_enable}};

  // line level as seen by the group: latch when output, pin when input
  assign level     = (io_out & dir_out) | (pin_in & ~dir_out);
  assign int_line  = level[`PDIO_BIT_INT_LINE];
  assign gate_line = level[`PDIO_BIT_GATE_LINE];

  // interrupt permission from jumpers and the gate line
  assign grp_int_en = always_jumper | (gated_jumper & ~gate_line);

  // rising edge of the interrupt line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_line_q <= 1'b0;
    end else begin
      int_line_q <= int_line;
    end
  end

  assign int_edge = int_line & ~int_line_q & grp_int_en;

  // read back: input ports show pins, output ports show latches
  always @* begin
    case (reg_sel)
      `PDIO_PORT_A: rdata = level[7:0];
      `PDIO_PORT_B: rdata = level[15:8];
      `PDIO_PORT_C: rdata = level[23:16];
      default:      rdata = {{(8-`PDIO_CTRL_W){1'b0}}, ctrl};
    endcase
  end

endmodule // pdio_group

// [logic/pdio_card.v]
// top of the buffered parallel i/o card: apb slave, up to five groups,
// card-wide interrupt latch, enable and mask
// assumes: apb master on pclk; field pins and jumpers asynchronous
//
// Functional notes
// - Each group has two 8-bit ports and port c as two 4-bit halves, each set to input or output.
// - Each port's line buffers follow the port's programmed direction automatically; here lines also drive only with control bit 4 or the forcing jumper set.
// - The number of populated groups is configurable to five, four or three.
// - With the buffer-always-on jumper and no software-tristate jumper, all line buffers stay enabled regardless of software.
// - With the software-tristate jumper, buffers are enabled or tristated only by software.
// - Each group dedicates one field line as an interrupt source.
// - A group's interrupt is enabled by its always jumper, or by its gated jumper with a low gate.
// - The card decodes 32 consecutive locations whose base the host assigns.
// - A rising edge on the interrupt line is latched as a pending request.
// - Software driving bit 3 of port c low then high also raises an interrupt.
// - Interrupts are off at reset; a write to 1f enables, a write to 1e clears and disables.
// - With the gated jumper and no always jumper, a high gate line blocks the group's interrupts.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "pdio_defs.vh"
module pdio_card #(
  parameter NUM_GROUPS = 5 // 5, 4 or 3
) (
  // clock and reset
  input  wire                      pclk,
  input  wire                      presetn,
  // apb slave
  input  wire                      psel,
  input  wire                      penable,
  input  wire                      pwrite,
  input  wire [`PDIO_ADDR_W-1:0]   paddr,
  input  wire [31:0]               pwdata,
  output reg  [31:0]               prdata,
  output wire                      pready,
  output wire                      pslverr,
  // field lines
  input  wire [`PDIO_FIELD_W-1:0]  field_in,
  output wire [`PDIO_FIELD_W-1:0]  field_out,
  output wire [`PDIO_FIELD_W-1:0]  field_oe,
  output wire [`PDIO_MAX_GROUPS-1:0] buffer_enable,
  // jumpers, high when installed
  input  wire                      buffer_always_on_jumper,
  input  wire                      software_tristate_jumper,
  input  wire [`PDIO_MAX_GROUPS-1:0] interrupt_always_jumper,
  input  wire [`PDIO_MAX_GROUPS-1:0] gated_interrupt_jumper,
  // interrupt
  output wire                      irq
);

  localparam SYNC_W = `PDIO_FIELD_W + 2 + 2 * `PDIO_MAX_GROUPS;
  localparam G      = `PDIO_MAX_GROUPS;

  wire [SYNC_W-1:0]          sync_q;
  wire [`PDIO_FIELD_W-1:0]   pins;
  wire                       ben_q;
  wire                       tst_q;
  wire [G-1:0]               ien_q;
  wire [G-1:0]               inp_q;
  wire [`PDIO_IDX_W-1:0]     idx;
  wire [2:0]                 grp;
  wire                       is_group;
  wire                       grp_ok;
  wire                       mapped;
  wire                       setup_ph;
  wire                       acc_wr;
  wire [G*8-1:0]             grp_rdata;
  wire [G-1:0]               edges;
  reg  [G-1:0]               int_status;
  reg  [G-1:0]               int_mask;
  reg                        int_global;
  reg  [G-1:0]               next_status;
  reg  [31:0]                rd_mux;

  // all pins and jumpers pass two flops first
  pdio_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({gated_interrupt_jumper, interrupt_always_jumper,
                software_tristate_jumper, buffer_always_on_jumper, field_in}),
    .sync_out (sync_q)
  );

  assign pins  = sync_q[`PDIO_FIELD_W-1:0];
  assign ben_q = sync_q[`PDIO_FIELD_W];
  assign tst_q = sync_q[`PDIO_FIELD_W+1];
  assign ien_q = sync_q[`PDIO_FIELD_W+2+G-1:`PDIO_FIELD_W+2];
  assign inp_q = sync_q[SYNC_W-1:`PDIO_FIELD_W+2+G];

  // address decode within the 32-word window
  assign idx      = paddr[`PDIO_ADDR_W-1:`PDIO_IDX_LSB];
  assign grp      = idx[4:2];
  assign is_group = (idx < `PDIO_IDX_STATUS);
  assign grp_ok   = is_group & ({29'h0, grp} < NUM_GROUPS);
  assign mapped   = grp_ok | (idx == `PDIO_IDX_STATUS) | (idx == `PDIO_IDX_MASK) |
                    (idx == `PDIO_IDX_STATE) | (idx == `PDIO_IDX_INT_OFF) |
                    (idx == `PDIO_IDX_INT_ON);
  assign setup_ph = psel & ~penable;
  assign acc_wr   = psel & penable & pwrite & mapped;

  // zero wait states; unmapped words answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // populated groups; the rest stay quiet
  genvar g;
  generate
    for (g = 0; g < G; g = g + 1) begin : gen_grp
      if (g < NUM_GROUPS) begin : pop
        pdio_group u_group (
          .pclk          (pclk),
          .presetn       (presetn),
          .wr_en         (acc_wr & grp_ok & (grp == g)),
          .reg_sel       (idx[1:0]),
          .wdata         (pwdata[7:0]),
          .rdata         (grp_rdata[g*8 +: 8]),
          .buffer_force  (ben_q & ~tst_q),
          .always_jumper (ien_q[g]),
          .gated_jumper  (inp_q[g]),
          .pin_in        (pins[g*24 +: 24]),
          .io_out        (field_out[g*24 +: 24]),
          .io_oe         (field_oe[g*24 +: 24]),
          .buffer_enable (buffer_enable[g]),
          .int_edge      (edges[g])
        );
      end else begin : empty
        assign grp_rdata[g*8 +: 8]  = 8'h00;
        assign field_out[g*24 +: 24] = 24'h000000;
        assign field_oe[g*24 +: 24]  = 24'h000000;
        assign buffer_enable[g]      = 1'b0;
        assign edges[g]              = 1'b0;
      end
    end
  endgenerate

  // sticky status: a new edge wins over a clear in the same cycle
  always @* begin
    next_status = int_status;
    if (acc_wr && idx == `PDIO_IDX_STATUS)
      next_status = int_status & ~pwdata[G-1:0];
    if (acc_wr && idx == `PDIO_IDX_INT_OFF)
      next_status = {G{1'b0}};
    next_status = next_status | (edges & {G{int_global}});
  end

  // interrupt registers, disabled at reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= {G{1'b0}};
      int_mask   <= `PDIO_MASK_RST;
      int_global <= 1'b0;
    end else begin
      int_status <= next_status;
      if (acc_wr && idx == `PDIO_IDX_MASK) begin
        int_mask <= pwdata[G-1:0];
      end
      if (acc_wr && idx == `PDIO_IDX_INT_ON) begin
        int_global <= 1'b1;
      end else if (acc_wr && idx == `PDIO_IDX_INT_OFF) begin
        int_global <= 1'b0;
      end
    end
  end

  assign irq = int_global & |(int_status & int_mask);

  // read mux
  always @* begin
    rd_mux = 32'h00000000;
    if (grp_ok) begin
      case (grp)
        3'h0:    rd_mux = {24'h000000, grp_rdata[7:0]};
        3'h1:    rd_mux = {24'h000000, grp_rdata[15:8]};
        3'h2:    rd_mux = {24'h000000, grp_rdata[23:16]};
        3'h3:    rd_mux = {24'h000000, grp_rdata[31:24]};
        default: rd_mux = {24'h000000, grp_rdata[39:32]};
      endcase
    end else begin
      case (idx)
        `PDIO_IDX_STATUS: rd_mux = {27'h0000000, int_status};
        `PDIO_IDX_MASK:   rd_mux = {27'h0000000, int_mask};
        `PDIO_IDX_STATE:  rd_mux = {17'h00000, inp_q, ien_q, 2'h0, tst_q, ben_q, int_global};
        default:          rd_mux = 32'h00000000;
      endcase
    end
  end

  // read data captured in the setup cycle, held through access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_ph) begin
      prdata <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

endmodule // pdio_card

// [tb/pdio_card_properties.sv]
// checker of the card's apb answers, buffer enables and interrupt output
// assumes: bound to pdio_card, sees only its ports
`timescale 1ns/1ps
`include "pdio_defs.vh"
module pdio_card_properties #(
  parameter NUM_GROUPS = 5
) (
  // clock and reset
  input wire                         pclk,
  input wire                         presetn,
  // apb
  input wire                         psel,
  input wire                         penable,
  input wire                         pwrite,
  input wire [`PDIO_ADDR_W-1:0]      paddr,
  input wire                         pready,
  input wire                         pslverr,
  // field side and jumpers
  input wire [`PDIO_FIELD_W-1:0]     field_oe,
  input wire [`PDIO_MAX_GROUPS-1:0]  buffer_enable,
  input wire                         buffer_always_on_jumper,
  input wire                         software_tristate_jumper,
  // interrupt
  input wire                         irq
);
  wire [4:0] idx    = paddr[6:2];
  wire       acc    = psel && penable;
  wire       acc_wr = acc && pwrite;
  reg        armed;
  // remembers a global enable since reset or the last clear
  always @(posedge pclk or negedge presetn)
    if (!presetn) armed <= 1'b0;
    else if (acc_wr && idx == `PDIO_IDX_INT_ON) armed <= 1'b1;
    else if (acc_wr && idx == `PDIO_IDX_INT_OFF) armed <= 1'b0;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_clear_wr;
    acc_wr && idx == `PDIO_IDX_INT_OFF;
  endsequence
  sequence s_forced;
    (buffer_always_on_jumper && !software_tristate_jumper)[*3];
  endsequence
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (acc && ((idx >= 4*NUM_GROUPS && idx < 5'h14) ||
    (idx > 5'h16 && idx < 5'h1e)) |-> pslverr) else $error("unmapped not refused");
  a_mapped_ok: assert property (acc && (idx < 4*NUM_GROUPS ||
    idx inside {5'h14, 5'h15, 5'h16, 5'h1e, 5'h1f}) |-> !pslverr) else $error("mapped refused");
  a_clear_kills: assert property (s_clear_wr |=> !irq)
    else $error("irq after clear");
  a_boot_quiet: assert property (!armed |-> !irq)
    else $error("irq while disabled");
  a_reset_inputs: assert property ($rose(presetn) |-> field_oe == '0)
    else $error("driving after reset");
  a_port_whole: assert property (field_oe[7:0] inside {8'h00, 8'hff} &&
    field_oe[15:8] inside {8'h00, 8'hff} && field_oe[19:16] inside {4'h0, 4'hf} &&
    field_oe[23:20] inside {4'h0, 4'hf}) else $error("port split");
  a_forced_on: assert property (s_forced |-> &buffer_enable[NUM_GROUPS-1:0])
    else $error("buffers not forced");
  a_oe_needs_buf: assert property (field_oe[23:0] != 24'h0 |-> buffer_enable[0])
    else $error("drive without buffer");
  a_spare_quiet: assert property (NUM_GROUPS == 5 ||
    (!buffer_enable[4] && field_oe[119:96] == 24'h0)) else $error("spare group active");
endmodule // pdio_card_properties

bind pdio_card pdio_card_properties #(.NUM_GROUPS(NUM_GROUPS)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .field_oe(field_oe),
  .buffer_enable(buffer_enable), .buffer_always_on_jumper(buffer_always_on_jumper),
  .software_tristate_jumper(software_tristate_jumper), .irq(irq));

// [tb/pdio_field_model.sv]
// field side of the card: pull-ups, external drivers, the card's buffers
// assumes: ext_oe and ext_val come from the bench, one bit per line
`timescale 1ns/1ps
`include "pdio_defs.vh"
module pdio_field_model (
  // card side
  input  wire [`PDIO_FIELD_W-1:0] field_out,
  input  wire [`PDIO_FIELD_W-1:0] field_oe,
  // external drivers
  input  wire [`PDIO_FIELD_W-1:0] ext_oe,
  input  wire [`PDIO_FIELD_W-1:0] ext_val,
  // resolved levels
  output wire [`PDIO_FIELD_W-1:0] field_in
);
  // card wins where it drives, else the far driver, else the pull-up
  assign field_in = (field_oe & field_out) | (~field_oe & ext_oe & ext_val) |
                    (~field_oe & ~ext_oe);
endmodule // pdio_field_model

// [tb/pdio_card_test.sv]
// self-checking bench of the parallel i/o card built with four groups
// assumes: design under logic/, field model and checker beside this file
`timescale 1ns/1ps
`include "pdio_defs.vh"
module pdio_card_test;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [6:0]   paddr = 7'h00;
  logic [31:0]  pwdata = 32'h0;
  logic         always_on = 1'b0;
  logic         sw_tri = 1'b1;
  logic [119:0] ext_oe = '0;
  logic [119:0] ext_val = '0;
  logic [119:0] field_in, field_out, field_oe;
  logic [31:0]  prdata, r;
  logic [31:0]  seed = 32'd76213;
  logic [4:0]   buf_en, c;
  logic         pready, pslverr, irq;
  logic [119:0] expq[$];
  int           error_cnt = 0;
  int           samples_checked = 0;

  always #2.5 pclk = ~pclk;
  pdio_card #(.NUM_GROUPS(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .field_in(field_in), .field_out(field_out),
    .field_oe(field_oe), .buffer_enable(buf_en), .buffer_always_on_jumper(always_on),
    .software_tristate_jumper(sw_tri), .interrupt_always_jumper(5'h01),
    .gated_interrupt_jumper(5'h02), .irq(irq));
  pdio_field_model u_field (.field_out(field_out), .field_oe(field_oe),
    .ext_oe(ext_oe), .ext_val(ext_val), .field_in(field_in));

  // xorshift source of stimulus
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // drive pattern of one group for a control value
  function automatic logic [23:0] oe_of(input logic [4:0] k);
    return k[4] ? {{4{~k[3]}}, {4{~k[2]}}, {8{~k[1]}}, {8{~k[0]}}} : 24'h0;
  endfunction
  // compares one result and counts it
  task chk(input logic [119:0] seen, input logic [119:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer; a read notes its expected {pslverr, prdata}
  task apb(input logic wr, input logic [4:0] idx, input logic [31:0] wd, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    if (!wr) expq.push_back({87'h0, e});
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // moves one field line and lets it cross the synchroniser
  task pin(input int n, input logic v);
    @(posedge pclk);
    ext_val[n] <= v;
    repeat (6) @(posedge pclk);
    #1;
  endtask
  // reports the counts and ends the run
  task print_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // takes the oldest note at each completed read
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      chk({87'h0, pslverr, prdata}, expq.pop_front());

  // watchdog
  initial begin
    #20000;
    error_cnt++;
    print_verdict();
  end

  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 5'h03, 0, 33'h0f);
    apb(0, 5'h00, 0, 33'hff);
    chk(field_oe, 0);
    ext_oe <= '1;
    for (int g = 0; g < 4; g++) begin
      r = rnd();
      c = (g == 0) ? 5'h1a : {1'b1, r[27:24]};
      ext_val[24*g +: 24] <= r[23:0];
      apb(1, 5'(4*g+3), {27'h0, c}, 0);
      apb(1, 5'(4*g), {24'h0, r[31:24]}, 0);
      repeat (4) @(posedge pclk);
      #1;
      chk(field_oe[24*g +: 24], oe_of(c));
      apb(0, 5'(4*g), 0, {25'h0, c[0] ? r[7:0] : r[31:24]});
    end
    chk(irq, 0);
    apb(1, 5'h03, 32'h0a, 0);
    #1;
    chk({buf_en[0], field_oe[23:0]}, 0);
    @(posedge pclk);
    always_on <= 1'b1;
    sw_tri <= 1'b0;
    repeat (4) @(posedge pclk);
    #1;
    chk({buf_en, field_oe[23:0]}, {5'h0f, oe_of(5'h1a)});
    @(posedge pclk);
    always_on <= 1'b0;
    sw_tri <= 1'b1;
    apb(0, 5'h10, 0, 33'h100000000);
    apb(0, 5'h18, 0, 33'h100000000);
    apb(1, 5'h1f, 0, 0);
    apb(1, 5'h02, 0, 0);
    apb(1, 5'h02, 32'h08, 0);
    repeat (3) @(posedge pclk);
    #1;
    chk(irq, 1);
    apb(0, 5'h14, 0, 33'h01);
    apb(1, 5'h14, 32'h01, 0);
    #1;
    chk(irq, 0);
    apb(1, 5'h07, 32'h1f, 0);
    pin(43, 0);
    pin(47, 1);
    apb(1, 5'h14, 32'h02, 0);
    pin(43, 1);
    chk(irq, 0);
    pin(43, 0);
    pin(47, 0);
    pin(43, 1);
    chk(irq, 1);
    apb(0, 5'h14, 0, 33'h02);
    apb(1, 5'h15, 0, 0);
    #1;
    chk(irq, 0);
    apb(1, 5'h15, 32'h1f, 0);
    #1;
    chk(irq, 1);
    apb(1, 5'h1e, 0, 0);
    #1;
    chk(irq, 0);
    pin(43, 0);
    pin(43, 1);
    apb(0, 5'h14, 0, 33'h0);
    print_verdict();
  end
endmodule // pdio_card_test
